/* File: src/strap_config_latch.v */
`include "strap_config_map.vh"
module strap_config_latch #(
  parameter SETTLE = `SETTLE_CYC
) (
  input wire mclk,
  input wire rst,
  input wire reset_pin_n,
  input wire soft_reset,
  input wire power_down,
  input wire port1_indicator_a,
  input wire port1_indicator_b,
  input wire port2_indicator_a,
  input wire port2_indicator_b,
  input wire [3:0] rx_data,
  input wire rx_error,
  input wire wake_event_out_n,
  input wire rx_valid,
  input wire spi_data_out,
  input wire start_switch_bit,
  input wire ptp_tick,
  input wire [1:0] gp_in,
  input wire [1:0] gp_dir_out,
  input wire [1:0] gp_out_val,
  input wire [1:0] gp_trigger,
  output reg straps_valid,
  output reg strap_pins_oe_n,
  output reg forward_enable,
  output reg inband_management,
  output reg mii_mac_mode,
  output reg rmii_ref_clock_out,
  output reg rmii_ref_clock_in,
  output reg inband_link_status,
  output reg speed_1000,
  output reg [1:0] xmii_mode,
  output reg xmii_reserved,
  output reg [1:0] host_if_mode,
  output reg phy_autoneg,
  output reg phy_eee,
  output reg phy_mdix,
  output reg phy_reserved,
  output reg factory_test,
  output reg [1:0] gp_sample,
  output reg [1:0] gp_capture,
  output reg [1:0] gp_drive,
  output reg [1:0] gp_oe_n
);

////////////////////////////////////////////////////////////////////////////
localparam S_HOLD = 2'h0;
localparam S_SETTLE = 2'h1;
localparam S_RUN = 2'h2;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [`SETTLE_W-1:0] cnt_r;
reg [`SETTLE_W-1:0] cnt_nxt;
reg [`STRAP_WIDTH-1:0] strap_r;
reg start_seen_r;
reg start_seen_nxt;
reg forward_nxt;
reg inband_mgmt_nxt;
reg ref_out_nxt;
reg ref_in_nxt;
reg link_status_nxt;
reg speed_1000_nxt;
reg xmii_rsvd_nxt;
reg [1:0] host_nxt;
reg autoneg_nxt;
reg eee_nxt;
reg mdix_nxt;
reg phy_rsvd_nxt;
reg test_nxt;
wire [`STRAP_WIDTH-1:0] strap_now;
wire sample_evt;
wire cfg_mii_mac;
wire [1:0] cfg_xmii;
wire [1:0] cfg_host;
wire [1:0] cfg_phy;

// Positions come from the map so capture and decode cannot drift apart
assign strap_now[`STRAP_P1A_BIT] = port1_indicator_a;
assign strap_now[`STRAP_P1B_BIT] = port1_indicator_b;
assign strap_now[`STRAP_P2A_BIT] = port2_indicator_a;
assign strap_now[`STRAP_P2B_BIT] = port2_indicator_b;
assign strap_now[`STRAP_RXD_HI:`STRAP_RXD_LO] = rx_data;
assign strap_now[`STRAP_PHY_LO] = wake_event_out_n;
assign strap_now[`STRAP_PHY_HI] = rx_error;
assign strap_now[`STRAP_TEST_LO] = rx_valid;
assign strap_now[`STRAP_TEST_HI] = spi_data_out;
// Any reset source forces straps back onto the pins
assign sample_evt = soft_reset | power_down | ~reset_pin_n;

////////////////////////////////////////////////////////////////////////////
// Sampling sequence: pins released to straps, settle, then latch
always @* begin
  state_nxt = state_r;
  cnt_nxt = cnt_r;
  case (state_r)
    S_HOLD: begin
      cnt_nxt = {`SETTLE_W{1'b0}};
      if (!sample_evt)
        state_nxt = S_SETTLE;
    end
    S_SETTLE: begin
      if (sample_evt) begin
        state_nxt = S_HOLD;
      end else if (cnt_r == SETTLE[`SETTLE_W-1:0] - 4'h1) begin
        state_nxt = S_RUN;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
    S_RUN: begin
      if (sample_evt)
        state_nxt = S_HOLD;
    end
    default: state_nxt = S_HOLD;
  endcase
end

always @(posedge mclk) begin
  if (rst) begin
    state_r <= S_HOLD;
    cnt_r <= {`SETTLE_W{1'b0}};
    strap_r <= `STRAP_DEFAULT;
  end else begin
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
    // Latch only on the settle-to-run step; frozen while running
    if (state_r == S_SETTLE && state_nxt == S_RUN)
      strap_r <= strap_now;
  end
end

////////////////////////////////////////////////////////////////////////////
// Decode of latched straps
assign cfg_mii_mac = strap_r[`STRAP_P2A_BIT];
assign cfg_xmii = strap_r[`STRAP_RXD_HI:`STRAP_RXD_HI-1];
assign cfg_phy = strap_r[`STRAP_PHY_HI:`STRAP_PHY_LO];
assign cfg_host = strap_r[`STRAP_RXD_LO+1:`STRAP_RXD_LO];

always @* begin
  // Start bit is remembered in RUN so a pulse from software there is enough
  start_seen_nxt = start_seen_r;
  if (state_r != S_RUN)
    start_seen_nxt = 1'b0;
  else if (start_switch_bit)
    start_seen_nxt = 1'b1;
  // Forwarding is held off outside RUN whatever the strap says
  forward_nxt = 1'b0;
  if (state_r == S_RUN) begin
    if (strap_r[`STRAP_P1A_BIT])
      forward_nxt = 1'b1;
    else
      forward_nxt = start_seen_r | start_switch_bit;
  end
  inband_mgmt_nxt = ~strap_r[`STRAP_P1B_BIT];
  speed_1000_nxt = ~strap_r[`STRAP_P2B_BIT];
  test_nxt = |strap_r[`STRAP_TEST_HI:`STRAP_TEST_LO];
  // Third port: clock direction and in-band status follow the MAC strap
  ref_out_nxt = 1'b0;
  ref_in_nxt = 1'b0;
  link_status_nxt = 1'b0;
  xmii_rsvd_nxt = 1'b0;
  case (cfg_xmii)
    `XMII_RMII: begin
      ref_out_nxt = ~cfg_mii_mac;
      ref_in_nxt = cfg_mii_mac;
    end
    `XMII_RGMII: begin
      link_status_nxt = cfg_mii_mac;
    end
    `XMII_RSVD: begin
      // Reserved code is passed on and flagged, not remapped
      xmii_rsvd_nxt = 1'b1;
    end
    default: begin
      xmii_rsvd_nxt = 1'b0;
    end
  endcase
  case (cfg_host)
    2'h0: host_nxt = `HOST_MIIM;
    2'h1: host_nxt = `HOST_I2C;
    default: host_nxt = `HOST_SPI;
  endcase
  autoneg_nxt = 1'b0;
  eee_nxt = 1'b0;
  mdix_nxt = 1'b0;
  phy_rsvd_nxt = 1'b0;
  case (cfg_phy)
    `PHY_ANEG_EEE: begin
      autoneg_nxt = 1'b1;
      eee_nxt = 1'b1;
    end
    `PHY_F100_MDIX: begin
      mdix_nxt = 1'b1;
    end
    `PHY_F100_MDI: begin
      mdix_nxt = 1'b0;
    end
    default: begin
      phy_rsvd_nxt = 1'b1;
    end
  endcase
end

always @(posedge mclk) begin
  if (rst) begin
    straps_valid <= 1'b0;
    strap_pins_oe_n <= 1'b1;
    start_seen_r <= 1'b0;
    forward_enable <= 1'b0;
    inband_management <= 1'b0;
    mii_mac_mode <= 1'b1;
    rmii_ref_clock_out <= 1'b0;
    rmii_ref_clock_in <= 1'b0;
    inband_link_status <= 1'b0;
    speed_1000 <= 1'b0;
    xmii_mode <= `XMII_MII;
    xmii_reserved <= 1'b0;
    host_if_mode <= `HOST_MIIM;
    phy_autoneg <= 1'b1;
    phy_eee <= 1'b1;
    phy_mdix <= 1'b0;
    phy_reserved <= 1'b0;
    factory_test <= 1'b0;
  end else begin
    straps_valid <= (state_r == S_RUN);
    // Shared pins stay released until straps are latched
    strap_pins_oe_n <= (state_r != S_RUN);
    start_seen_r <= start_seen_nxt;
    forward_enable <= forward_nxt;
    inband_management <= inband_mgmt_nxt;
    mii_mac_mode <= cfg_mii_mac;
    rmii_ref_clock_out <= ref_out_nxt;
    rmii_ref_clock_in <= ref_in_nxt;
    inband_link_status <= link_status_nxt;
    speed_1000 <= speed_1000_nxt;
    xmii_mode <= cfg_xmii;
    xmii_reserved <= xmii_rsvd_nxt;
    host_if_mode <= host_nxt;
    phy_autoneg <= autoneg_nxt;
    phy_eee <= eee_nxt;
    phy_mdix <= mdix_nxt;
    phy_reserved <= phy_rsvd_nxt;
    factory_test <= test_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////
// General purpose timing pins, advanced on the precision-time tick
// Pin edges show three ticks late; pulses shorter than a tick may be lost
genvar g;
generate
  for (g = 0; g < 2; g = g + 1) begin : gp
    reg sync1_r;
    reg sync2_r;
    reg prev_r;
    wire rise_w;
    assign rise_w = sync2_r & ~prev_r;
    always @(posedge mclk) begin
      if (rst) begin
        sync1_r <= 1'b1;
        sync2_r <= 1'b1;
        prev_r <= 1'b1;
        gp_sample[g] <= 1'b1;
        gp_capture[g] <= 1'b0;
        gp_drive[g] <= 1'b1;
        gp_oe_n[g] <= 1'b1;
      end else begin
        gp_capture[g] <= 1'b0;
        if (ptp_tick) begin
          sync1_r <= gp_in[g];
          sync2_r <= sync1_r;
          prev_r <= sync2_r;
          gp_sample[g] <= sync2_r;
          // Capture fires on a rising edge while the pin is an input
          if (!gp_dir_out[g])
            gp_capture[g] <= rise_w;
          gp_drive[g] <= gp_out_val[g] ^ gp_trigger[g];
          gp_oe_n[g] <= ~gp_dir_out[g];
        end
      end
    end
  end
endgenerate

endmodule

/* File: src/strap_config_map.vh */
`ifndef STRAP_CONFIG_MAP_VH
`define STRAP_CONFIG_MAP_VH
// Strap word bit positions
`define STRAP_P1A_BIT 0
`define STRAP_P1B_BIT 1
`define STRAP_P2A_BIT 2
`define STRAP_P2B_BIT 3
`define STRAP_RXD_LO 4
`define STRAP_RXD_HI 7
`define STRAP_PHY_LO 8
`define STRAP_PHY_HI 9
`define STRAP_TEST_LO 10
`define STRAP_TEST_HI 11
`define STRAP_WIDTH 12
// Defaults as given by internal pull-ups / documented defaults
`define STRAP_DEFAULT 12'h10F
// Port-three interface codes
`define XMII_MII 2'h0
`define XMII_RMII 2'h1
`define XMII_RSVD 2'h2
`define XMII_RGMII 2'h3
// Host serial interface codes
`define HOST_MIIM 2'h0
`define HOST_I2C 2'h1
`define HOST_SPI 2'h2
// PHY configuration codes
`define PHY_RSVD 2'h0
`define PHY_ANEG_EEE 2'h1
`define PHY_F100_MDIX 2'h2
`define PHY_F100_MDI 2'h3
// Sampling sequence timing
`define SETTLE_NS 40
`define CLK_NS 4
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_W 4
`endif

/* File: verif/strap_checker_assertions.sv */
module strap_checker (
  input wire mclk,
  input wire rst,
  input wire reset_pin_n,
  input wire soft_reset,
  input wire power_down,
  input wire straps_valid,
  input wire forward_enable,
  input wire strap_pins_oe_n,
  input wire mii_mac_mode,
  input wire rmii_ref_clock_out,
  input wire rmii_ref_clock_in,
  input wire inband_link_status,
  input wire [1:0] xmii_mode,
  input wire xmii_reserved,
  input wire [1:0] host_if_mode,
  input wire phy_autoneg,
  input wire phy_eee,
  input wire phy_reserved,
  input wire factory_test
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire quiet = reset_pin_n & !soft_reset & !power_down;
  valid_rise_a: assert property (
    $rose(straps_valid) |-> $past(quiet, 1) && $past(quiet, 2))
    else $error("straps latched while a reset source was active");
  pin_release_a: assert property (
    strap_pins_oe_n != straps_valid) else $error("strap pin drive wrong");
  rsvd_flag_a: assert property (
    xmii_reserved == (xmii_mode == 2'h2)) else $error("reserved flag wrong");
  clk_out_a: assert property (
    rmii_ref_clock_out == (xmii_mode == 2'h1 && !mii_mac_mode))
    else $error("reference clock output wrong");
  clk_in_a: assert property (
    rmii_ref_clock_in == (xmii_mode == 2'h1 && mii_mac_mode))
    else $error("reference clock input wrong");
  link_status_a: assert property (
    inband_link_status == (xmii_mode == 2'h3 && mii_mac_mode))
    else $error("in-band status wrong");
  host_code_a: assert property (
    host_if_mode != 2'h3) else $error("host mode code out of range");
  phy_pair_a: assert property (
    phy_eee == phy_autoneg && !(phy_reserved && phy_autoneg))
    else $error("phy decode inconsistent");
  hold_cfg_a: assert property (
    !quiet |-> ##2 ($stable(xmii_mode) && $stable(host_if_mode)
    && $stable(factory_test))) else $error("decode moved during reset");
  fwd_gate_a: assert property (
    forward_enable |-> straps_valid)
    else $error("forwarding before straps latched");
endmodule
bind strap_config_latch strap_checker i_strap_checker (.*);

/* File: verif/board_straps.sv */
module board_straps (
  input wire mclk,
  input wire oe_n,
  input wire [11:0] word,
  output wire [11:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_r = 1'h0;
  always @(posedge mclk) flip_r <= ~flip_r;
  // Once the device drives the pins, resistor levels are gone
  // Test straps stay low except where a row asks otherwise
  assign pins = oe_n ? word : ({12{flip_r}} ^ ~word);
endmodule

/* File: verif/strap_config_latch_test.sv */
module strap_config_latch_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic reset_pin_n = 1'h1;
  logic soft_reset = 1'h0;
  logic power_down = 1'h0;
  logic start_switch_bit = 1'h0;
  logic [11:0] word = 12'h10F;
  logic ptp_tick = 1'h0;
  logic [1:0] gp_in = 2'h3;
  logic [1:0] gp_dir_out = 2'h0;
  logic [1:0] gp_out_val = 2'h0;
  logic [1:0] gp_trigger = 2'h0;
  wire [11:0] pins;
  wire straps_valid, strap_pins_oe_n, forward_enable, inband_management;
  wire mii_mac_mode, rmii_ref_clock_out, rmii_ref_clock_in, speed_1000;
  wire inband_link_status, xmii_reserved, factory_test, phy_eee;
  wire phy_autoneg, phy_mdix, phy_reserved;
  wire [1:0] xmii_mode, host_if_mode;
  wire [14:0] got = {forward_enable, inband_management, mii_mac_mode,
    speed_1000, xmii_mode, host_if_mode, phy_autoneg, phy_mdix,
    phy_reserved, factory_test, rmii_ref_clock_out, rmii_ref_clock_in,
    inband_link_status};
  wire [1:0] gp_sample, gp_capture, gp_drive, gp_oe_n;
  wire [14:0] gp_all = {7'h0, gp_sample, gp_capture, gp_drive, gp_oe_n};
  wire [14:0] ctl = {11'h0, straps_valid, strap_pins_oe_n, forward_enable,
    mii_mac_mode};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // Strap word beside the decode it must give
  localparam logic [26:0] rows [6] = '{{12'h10F, 15'h5040},
    {12'h251, 15'h6AA4}, {12'h3EF, 15'h5701}, {12'h17F, 15'h5342},
    {12'h48F, 15'h5418}, {12'h90F, 15'h5048}};
  board_straps i_board_straps (.mclk, .oe_n(strap_pins_oe_n), .word, .pins);
  // Short settle keeps each sampling round to a handful of cycles
  strap_config_latch #(.SETTLE(2)) i_strap_config_latch (.*,
    .port1_indicator_a(pins[0]), .port1_indicator_b(pins[1]),
    .port2_indicator_a(pins[2]), .port2_indicator_b(pins[3]),
    .rx_data(pins[7:4]), .wake_event_out_n(pins[8]), .rx_error(pins[9]),
    .rx_valid(pins[10]), .spi_data_out(pins[11]));
  // Fixed-period clock stands in for the board reference
  always #2 mclk = ~mclk;
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [14:0] exp, input logic [14:0] act);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h want %h", $time, act, exp);
    end
  endtask
  // Source 0 soft reset, 1 power-down, 2 reset pin
  task automatic strap(input logic [11:0] w, input int src);
    word = w;
    soft_reset = src == 0;
    power_down = src == 1;
    reset_pin_n = src != 2;
    tick(2);
    soft_reset = 1'h0;
    power_down = 1'h0;
    reset_pin_n = 1'h1;
    tick(5);
  endtask
  initial begin
    tick(3);
    check(15'h5, ctl);
    rst = 1'h0;
    tick(1);
    foreach (rows[i]) begin
      strap(rows[i][26:15], i % 3);
      check(rows[i][14:0], got);
      tick(4);
      check(rows[i][14:0], got);
    end
    strap(12'h10E, 0);
    check(15'h0, {14'h0, forward_enable});
    start_switch_bit = 1'h1;
    tick(1);
    start_switch_bit = 1'h0;
    tick(2);
    check(15'h1, {14'h0, forward_enable});
    // A source that returns during the settle time restarts it
    word = 12'h3EF;
    soft_reset = 1'h1;
    tick(2);
    soft_reset = 1'h0;
    tick(1);
    power_down = 1'h1;
    tick(1);
    power_down = 1'h0;
    tick(2);
    check(15'h0, {14'h0, straps_valid});
    tick(3);
    check(15'h5701, got);
    // Pin 0 as capture input, pin 1 as trigger output
    gp_dir_out = 2'h2;
    gp_out_val = 2'h3;
    gp_trigger = 2'h2;
    gp_in = 2'h0;
    ptp_tick = 1'h1;
    tick(4);
    check(15'h05, gp_all);
    gp_in = 2'h3;
    tick(3);
    check(15'hD5, gp_all);
    tick(1);
    check(15'hC5, gp_all);
    // Without the tick the timing pins hold; only gp_capture still clears on each clock
    ptp_tick = 1'h0;
    gp_in = 2'h0;
    gp_dir_out = 2'h1;
    tick(4);
    check(15'hC5, gp_all);
    ptp_tick = 1'h1;
    tick(1);
    ptp_tick = 1'h0;
    tick(1);
    check(15'hC6, gp_all);
    // Reset in mid-run returns every output to its reset value
    rst = 1'h1;
    tick(1);
    check(15'h5, ctl);
    check(15'h1040, got);
    check(15'hCF, gp_all);
    rst = 1'h0;
    word = 12'h251;
    tick(5);
    check(15'h6AA4, got);
    close_out();
  end
endmodule
